/* src/svs_supervisor.sv */
// supply voltage supervisor: sequencer, monitor, messages, apb registers
// Operation
// - poll upper comparator every 10 ms after reset
// - stable after ten passing samples, failure restarts
// - when stable arm monitor, send start, run
// - below upper: toggle alarm each second, request
// - normal: count port increments every 0.5 s
// - handler reads passage flag, no filtering
// - single flag reading decides, no re-check
// - downward crossing: under message, polarity to 0
// - upward crossing: over message, polarity to 1
// - below lower threshold: full restart, recheck
// - level compare status bit shows supply above
// - option bit enables lower reset after reset
// - option byte at FFFFFh holds 09Fh
// - serial 38400 bps, 8N1, no flow control
// - clear passage flag before enabling monitor
// - filter disable bit bypasses the filter
// - mode bit: 0 interrupt, 1 reset
`timescale 1ns/1ns
`include "svs_map.svh"
module svs_supervisor #(
    parameter int TICK_CYC = `SVS_TICK_CYC,
    parameter int BAUD_CYC = `SVS_BAUD_CYC,
    parameter logic [7:0] OPT_SEL = `SVS_OPTSEL_RST
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [23:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // detector comparators
    input wire logic above_upper_i,
    input wire logic above_lower_i,
    // ports and interrupt
    output logic [2:0] count_o,
    output logic alarm_o,
    output logic txd_o,
    output logic irq_o
);
    svs_byte_if tx_if ();

    logic tick;
    logic restart;
    logic lvr_en;
    // sequencer state
    svs_pkg::svs_state_e state;
    svs_pkg::svs_state_e next_state;
    logic [3:0] samples;
    logic [3:0] next_samples;
    logic [6:0] iv;
    logic [6:0] next_iv;
    logic set_sent;
    logic next_set_sent;
    logic next_alarm;
    logic [2:0] next_count;
    logic [3:0] pend;
    logic [3:0] next_pend;
    logic mon_en, mon_fdis, mon_flag, mon_mode, mon_pol;
    logic next_en, next_fdis, next_flag, next_mode, next_pol;
    logic f1, f2, lvl_f, lvl_prev;
    logic next_f1, next_f2, next_lvl_f;
    logic fire;
    logic [2:0] irq_stat;
    logic [2:0] next_stat;
    logic [2:0] irq_mask;
    logic [2:0] next_mask;
    logic next_irq;
    // message sender state
    logic sending;
    logic next_sending;
    svs_pkg::svs_msg_e msg_id;
    svs_pkg::svs_msg_e next_msg_id;
    logic [2:0] msg_idx;
    logic [2:0] next_msg_idx;
    logic take;
    svs_pkg::svs_msg_e take_id;
    // bus state
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic access;
    logic wr;

    // lower-threshold reset armed straight from reset by option byte
    assign lvr_en = ~OPT_SEL[`SVS_OPT_LVR_BIT];
    assign restart = lvr_en & ~above_lower_i;
    assign access = psel_i & penable_i & ~pready_o;
    // writes land on the edge that completes the transfer
    assign wr = psel_i & penable_i & pwrite_i & pready_o;

    svs_tick #(
        .CYC(TICK_CYC)
    ) u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(restart),
        .tick_o(tick)
    );

    svs_uart_tx #(
        .BAUD_CYC(BAUD_CYC)
    ) u_tx (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in(tx_if.snk),
        .txd_o(txd_o)
    );

    // ---------------- sequencer and monitor ----------------
    // crossing fires on rise with polarity 0, on fall with polarity 1
    assign fire = mon_en & (mon_pol ? (lvl_prev & ~lvl_f)
                                    : (~lvl_prev & lvl_f));

    always_comb begin
        next_state = state;
        next_samples = samples;
        next_iv = iv;
        next_set_sent = set_sent;
        next_alarm = alarm_o;
        next_count = count_o;
        next_pend = pend;
        next_en = mon_en;
        next_fdis = mon_fdis;
        next_flag = mon_flag;
        next_mode = mon_mode;
        next_pol = mon_pol;
        next_stat = irq_stat;
        next_mask = irq_mask;
        next_f1 = above_upper_i;
        next_f2 = f1;
        // filter wants two agreeing samples; bypass takes the raw level
        next_lvl_f = (f1 == f2) ? f2 : lvl_f;
        if (mon_fdis) begin
            next_lvl_f = above_upper_i;
        end
        if (take) begin
            next_pend[take_id] = 1'b0;
        end
        // software writes
        if (wr && paddr_i == `SVS_OFF_MON_CTRL) begin
            next_en = pwdata_i[`SVS_CTL_EN];
            next_fdis = pwdata_i[`SVS_CTL_FDIS];
            next_mode = pwdata_i[`SVS_CTL_MODE];
            next_pol = pwdata_i[`SVS_CTL_POL];
            if (!pwdata_i[`SVS_CTL_FLAG]) begin
                next_flag = 1'b0;
            end
        end
        if (wr && paddr_i == `SVS_OFF_IRQ_STATUS) begin
            next_stat = irq_stat & ~pwdata_i[2:0];
        end
        if (wr && paddr_i == `SVS_OFF_IRQ_MASK) begin
            next_mask = pwdata_i[2:0];
        end
        case (state)
            svs_pkg::ST_POLL: begin
                if (tick) begin
                    next_iv = iv + 7'd1;
                    if (above_upper_i) begin
                        next_samples = samples + 4'd1;
                        if (samples == 4'(`SVS_STABLE_SAMPLES - 1)) begin
                            next_state = svs_pkg::ST_ARM;
                        end
                    end else begin
                        next_samples = 4'd0;
                        if (!set_sent) begin
                            next_set_sent = 1'b1;
                            next_pend[svs_pkg::MSG_SETSUP] = 1'b1;
                        end
                    end
                    if (iv == 7'(`SVS_ALARM_TICKS - 1)) begin
                        next_iv = 7'd0;
                        // alarm only runs once a low sample was seen
                        next_alarm = alarm_o ^ set_sent;
                    end
                end
            end
            svs_pkg::ST_ARM: begin
                next_flag = 1'b0;
                next_fdis = 1'b1;
                next_mode = 1'b0;
                next_pol = 1'b1;
                next_en = 1'b1;
                next_pend[svs_pkg::MSG_START] = 1'b1;
                next_stat[`SVS_IRQ_START] = 1'b1;
                next_alarm = 1'b0;
                next_count = 3'd0;
                next_iv = 7'd0;
                next_samples = 4'd0;
                next_state = svs_pkg::ST_NORMAL;
            end
            svs_pkg::ST_NORMAL: begin
                if (tick) begin
                    next_iv = iv + 7'd1;
                    if (iv == 7'(`SVS_COUNT_TICKS - 1)) begin
                        next_iv = 7'd0;
                        next_count = count_o + 3'd1;
                    end
                end
                // one look at the flag decides, no re-check
                if (mon_en && mon_flag) begin
                    if (mon_mode) begin
                        // reset mode: the ports restart as after reset
                        next_state = svs_pkg::ST_POLL;
                        next_en = 1'b0;
                        next_set_sent = 1'b0;
                        next_count = 3'd0;
                        next_alarm = 1'b0;
                        next_iv = 7'd0;
                        next_samples = 4'd0;
                    end else if (above_upper_i) begin
                        next_pend[svs_pkg::MSG_OVER] = 1'b1;
                        next_pol = 1'b1;
                    end else begin
                        next_pend[svs_pkg::MSG_UNDER] = 1'b1;
                        next_pol = 1'b0;
                    end
                    next_flag = 1'b0;
                end
            end
            default: begin
                next_state = svs_pkg::ST_POLL;
            end
        endcase
        // a crossing in the clearing cycle is kept
        if (fire) begin
            next_flag = 1'b1;
            next_stat[`SVS_IRQ_PASSAGE] = 1'b1;
        end
        if (restart) begin
            next_state = svs_pkg::ST_POLL;
            next_samples = 4'd0;
            next_iv = 7'd0;
            next_set_sent = 1'b0;
            next_alarm = 1'b0;
            next_count = 3'd0;
            next_en = 1'b0;
            next_flag = 1'b0;
            next_pol = 1'b0;
            next_stat[`SVS_IRQ_LOWRST] = 1'b1;
        end
        next_irq = |(next_stat & next_mask);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= svs_pkg::ST_POLL;
            samples <= 4'h0;
            iv <= 7'h00;
            set_sent <= 1'b0;
            alarm_o <= 1'b0;
            count_o <= 3'h0;
            pend <= 4'h0;
            mon_en <= 1'b0;
            mon_fdis <= 1'b0;
            mon_flag <= 1'b0;
            mon_mode <= 1'b0;
            mon_pol <= 1'b0;
            f1 <= 1'b0;
            f2 <= 1'b0;
            lvl_f <= 1'b0;
            lvl_prev <= 1'b0;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            state <= next_state;
            samples <= next_samples;
            iv <= next_iv;
            set_sent <= next_set_sent;
            alarm_o <= next_alarm;
            count_o <= next_count;
            pend <= next_pend;
            mon_en <= next_en;
            mon_fdis <= next_fdis;
            mon_flag <= next_flag;
            mon_mode <= next_mode;
            mon_pol <= next_pol;
            f1 <= next_f1;
            f2 <= next_f2;
            lvl_f <= next_lvl_f;
            lvl_prev <= lvl_f;
            irq_stat <= next_stat;
            irq_mask <= next_mask;
            irq_o <= next_irq;
        end
    end

    // ---------------- message sender ----------------
    function automatic logic [7:0] msg_char(svs_pkg::svs_msg_e m,
                                            logic [2:0] i);
        logic [55:0] txt;
        case (m)
            svs_pkg::MSG_START: txt = "START\r\n";
            svs_pkg::MSG_SETSUP: txt = "SET5V\r\n";
            svs_pkg::MSG_UNDER: txt = "UNDER\r\n";
            default: txt = "OVER \r\n";
        endcase
        return txt[55 - 8 * i -: 8];
    endfunction

    // lowest pending message goes first; none is lost while busy
    assign take = ~sending & (|pend);
    assign take_id = pend[0] ? svs_pkg::MSG_START :
                     pend[1] ? svs_pkg::MSG_SETSUP :
                     pend[2] ? svs_pkg::MSG_UNDER : svs_pkg::MSG_OVER;
    assign tx_if.valid = sending;
    assign tx_if.data = msg_char(msg_id, msg_idx);

    always_comb begin
        next_sending = sending;
        next_msg_id = msg_id;
        next_msg_idx = msg_idx;
        if (take) begin
            next_sending = 1'b1;
            next_msg_id = take_id;
            next_msg_idx = 3'd0;
        end else if (sending && tx_if.ready) begin
            next_msg_idx = msg_idx + 3'd1;
            if (msg_idx == 3'd6) begin
                next_sending = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sending <= 1'b0;
            msg_id <= svs_pkg::MSG_START;
            msg_idx <= 3'h0;
        end else begin
            sending <= next_sending;
            msg_id <= next_msg_id;
            msg_idx <= next_msg_idx;
        end
    end

    // ---------------- apb read and response ----------------
    always_comb begin
        next_prdata = prdata_o;
        next_pslverr = 1'b0;
        next_pready = access;
        if (access) begin
            next_prdata = 32'h00000000;
            case (paddr_i)
                `SVS_OFF_MON_CTRL: begin
                    next_prdata[`SVS_CTL_EN] = mon_en;
                    next_prdata[`SVS_CTL_FDIS] = mon_fdis;
                    next_prdata[`SVS_CTL_FLAG] = mon_flag;
                    next_prdata[`SVS_CTL_MODE] = mon_mode;
                    next_prdata[`SVS_CTL_POL] = mon_pol;
                end
                `SVS_OFF_DET_STATUS: begin
                    next_prdata[`SVS_DST_LOWER_OK] = above_lower_i;
                    next_prdata[`SVS_DST_LEVEL] = above_upper_i;
                end
                `SVS_OFF_IRQ_STATUS: next_prdata[2:0] = irq_stat;
                `SVS_OFF_IRQ_MASK: next_prdata[2:0] = irq_mask;
                `SVS_OFF_COUNT: next_prdata[2:0] = count_o;
                24'(`SVS_OFF_OPTION_SEL): next_prdata[7:0] = OPT_SEL;
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end
endmodule

/* shared/svs_map.svh */
// register map, field positions, reset values and timing counts
`ifndef SVS_MAP_SVH
`define SVS_MAP_SVH

// clock and times in their own units
`define SVS_CLK_HZ 25000000
`define SVS_POLL_MS 10
`define SVS_STABLE_MS 100
`define SVS_COUNT_MS 500
`define SVS_ALARM_MS 1000
`define SVS_BAUD 38400

// derived counts (baud divider rounds down: 651 cycles a bit)
`define SVS_TICK_CYC (`SVS_CLK_HZ / 1000 * `SVS_POLL_MS)
`define SVS_STABLE_SAMPLES (`SVS_STABLE_MS / `SVS_POLL_MS)
`define SVS_COUNT_TICKS (`SVS_COUNT_MS / `SVS_POLL_MS)
`define SVS_ALARM_TICKS (`SVS_ALARM_MS / `SVS_POLL_MS)
`define SVS_BAUD_CYC (`SVS_CLK_HZ / `SVS_BAUD)

// byte addresses on the register bus
`define SVS_OFF_MON_CTRL 24'h000000
`define SVS_OFF_DET_STATUS 24'h000004
`define SVS_OFF_IRQ_STATUS 24'h000008
`define SVS_OFF_IRQ_MASK 24'h00000c
`define SVS_OFF_COUNT 24'h000010
`define SVS_IDX_OPTION_SEL 24'h0fffff
`define SVS_OFF_OPTION_SEL (`SVS_IDX_OPTION_SEL * 4)

// monitor_two_control fields
`define SVS_CTL_EN 0
`define SVS_CTL_FDIS 1
`define SVS_CTL_FLAG 2
`define SVS_CTL_MODE 6
`define SVS_CTL_POL 7

// detector_status_reg fields
`define SVS_DST_LOWER_OK 0
`define SVS_DST_LEVEL 3

// interrupt status / mask fields
`define SVS_IRQ_PASSAGE 0
`define SVS_IRQ_START 1
`define SVS_IRQ_LOWRST 2

// option select byte; lowvolt_reset_autostart is active low
`define SVS_OPTSEL_RST 8'h9f
`define SVS_OPT_LVR_BIT 5

`endif

/* shared/svs_pkg.sv */
// types shared by the supply supervisor modules
package svs_pkg;
    typedef enum logic [1:0] {
        ST_POLL,
        ST_ARM,
        ST_NORMAL
    } svs_state_e;

    typedef enum logic [1:0] {
        MSG_START,
        MSG_SETSUP,
        MSG_UNDER,
        MSG_OVER
    } svs_msg_e;
endpackage

/* shared/svs_byte_if.sv */
// byte stream between the message sender and the serial transmitter
`timescale 1ns/1ns
interface svs_byte_if;
    logic valid;
    logic ready;
    logic [7:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* src/svs_tick.sv */
// periodic one-cycle pulse generator
`timescale 1ns/1ns
module svs_tick #(
    parameter int CYC = 250000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control and pulse
    input wire logic clr_i,
    output logic tick_o
);
    localparam int W = $clog2(CYC + 1);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_cnt = cnt + W'(1);
        next_tick = 1'b0;
        if (clr_i) begin
            next_cnt = '0;
        end else if (cnt == W'(CYC - 1)) begin
            next_cnt = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule

/* src/svs_uart_tx.sv */
// serial transmitter: 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ns
`include "svs_map.svh"
module svs_uart_tx #(
    parameter int BAUD_CYC = `SVS_BAUD_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // byte stream in
    svs_byte_if.snk in,
    // serial line
    output logic txd_o
);
    localparam int W = $clog2(BAUD_CYC + 1);
    logic busy;
    logic [8:0] shreg;
    logic [3:0] nbits;
    logic [W-1:0] bcnt;
    logic next_busy;
    logic [8:0] next_shreg;
    logic [3:0] next_nbits;
    logic [W-1:0] next_bcnt;
    logic next_txd;

    assign in.ready = ~busy;

    always_comb begin
        next_busy = busy;
        next_shreg = shreg;
        next_nbits = nbits;
        next_bcnt = bcnt;
        next_txd = txd_o;
        if (!busy) begin
            if (in.valid) begin
                // start bit now, then data lsb first, then stop
                next_busy = 1'b1;
                next_txd = 1'b0;
                next_shreg = {1'b1, in.data};
                next_nbits = 4'd9;
                next_bcnt = '0;
            end
        end else if (bcnt == W'(BAUD_CYC - 1)) begin
            next_bcnt = '0;
            if (nbits == 4'd0) begin
                next_busy = 1'b0;
            end else begin
                next_txd = shreg[0];
                next_shreg = {1'b1, shreg[8:1]};
                next_nbits = nbits - 4'd1;
            end
        end else begin
            next_bcnt = bcnt + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy <= 1'b0;
            shreg <= 9'h1ff;
            nbits <= 4'h0;
            bcnt <= '0;
            txd_o <= 1'b1;
        end else begin
            busy <= next_busy;
            shreg <= next_shreg;
            nbits <= next_nbits;
            bcnt <= next_bcnt;
            txd_o <= next_txd;
        end
    end
endmodule

/* dv/svs_supervisor_monitor.sv */
// port assertions for the supply supervisor
`timescale 1ns/1ns
module svs_supervisor_monitor #(
    parameter int TICK_CYC = 250000,
    parameter int BAUD_CYC = 651
) (
    // clock, reset and inputs
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic above_lower_i,
    // watched outputs
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [2:0] count_o,
    input wire logic alarm_o,
    input wire logic txd_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_rst_val;
        $rose(rst_n_i) |-> txd_o && !alarm_o && count_o == 3'h0;
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("outputs not at reset value");

    property p_ans;
        $rose(penable_i) && psel_i |=> pready_o;
    endproperty
    a_ans: assert property (p_ans)
        else $error("no answer after one wait state");

    property p_cause;
        pready_o |-> $past(psel_i && penable_i) && !$past(pready_o);
    endproperty
    a_cause: assert property (p_cause)
        else $error("ready without an access phase");

    property p_err;
        pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0);
    endproperty
    a_err: assert property (p_err)
        else $error("error response malformed");

    property p_cnt_inc;
        $changed(count_o) |-> count_o == $past(count_o) + 3'h1
            || count_o == 3'h0;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc)
        else $error("count port did not step by one");

    property p_cnt_hold;
        $changed(count_o) && count_o != 3'h0
            |=> ($stable(count_o) || count_o == 3'h0) [*8];
    endproperty
    a_cnt_hold: assert property (p_cnt_hold)
        else $error("count port stepped too soon");

    property p_low_rst;
        !above_lower_i |-> ##[1:3] (count_o == 3'h0 && !alarm_o);
    endproperty
    a_low_rst: assert property (p_low_rst)
        else $error("lower threshold did not restart");

    property p_alarm_hold;
        $changed(alarm_o) |=> ($stable(alarm_o) || !alarm_o) [*8];
    endproperty
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("alarm toggled too soon");

    // holds only while BAUD_CYC is at least 4
    property p_start_bit;
        $fell(txd_o) |=> (!txd_o) [*3];
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("serial low bit too short");
endmodule

bind svs_supervisor svs_supervisor_monitor #(
    .TICK_CYC(TICK_CYC),
    .BAUD_CYC(BAUD_CYC)
) u_mon (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i),
    .above_lower_i(above_lower_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .count_o(count_o),
    .alarm_o(alarm_o), .txd_o(txd_o)
);

/* dv/svs_pc_model.sv */
// pc side serial receiver: 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
module svs_pc_model #(
    parameter int BAUD_CYC = 651
) (
    // clock and serial line
    input wire logic clk_i,
    input wire logic txd_i
);
    logic [7:0] q[$];
    logic [7:0] b;
    int n_bad = 0;

    // sampled on the falling clock, away from the line's launch edge
    initial begin
        forever begin
            @(negedge txd_i);
            repeat (BAUD_CYC / 2) @(negedge clk_i);
            if (txd_i !== 1'b0)
                n_bad++;
            for (int i = 0; i < 8; i++) begin
                repeat (BAUD_CYC) @(negedge clk_i);
                b[i] = txd_i;
            end
            repeat (BAUD_CYC) @(negedge clk_i);
            if (txd_i !== 1'b1)
                n_bad++;
            q.push_back(b);
        end
    end
endmodule

/* dv/svs_supervisor_tb.sv */
// self-checking bench for the supply supervisor
`timescale 1ns/1ns
module svs_supervisor_tb;
    localparam int TK = 20;
    localparam int BD = 4;
    logic clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, above_upper_i = 0, above_lower_i = 1;
    logic [23:0] paddr_i = 24'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, r;
    logic [31:0] x = 32'h0000004e;
    logic pready_o, pslverr_o, alarm_o, txd_o, irq_o, e, u;
    logic [2:0] count_o, c;
    int n_fail = 0, tests_run = 0, k;

    svs_supervisor #(.TICK_CYC(TK), .BAUD_CYC(BD)) uut (
        .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .above_upper_i,
        .above_lower_i, .count_o, .alarm_o, .txd_o, .irq_o
    );
    svs_pc_model #(.BAUD_CYC(BD)) pc (.clk_i, .txd_i(txd_o));

    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // armed control: enable, filter bypass, interrupt mode, flag clear
    function automatic logic [31:0] ctl_exp(input logic pol);
        return {24'h0, pol, 7'h03};
    endfunction

    function automatic logic [31:0] dst_exp(input logic up);
        return {28'h0, up, 3'h1};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic w, input logic [23:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        // pready, read data and error are taken at the completing edge
        do begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 40);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (k >= 40)
            n_fail++;
    endtask

    // 0: alarm changes, 1: count changes, 2: irq high
    task automatic wt(input int w, input int lim, output int n);
        logic a0;
        logic [2:0] c0;
        a0 = alarm_o;
        c0 = count_o;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (n < lim && !(w == 0 ? alarm_o !== a0 :
                   w == 1 ? count_o !== c0 : irq_o === 1'b1));
    endtask

    task automatic msg(input string s);
        k = 0;
        while (pc.q.size() < 7 && k < 3000) begin
            @(negedge clk_i);
            k++;
        end
        for (int i = 0; i < 7; i++)
            chk({24'h0, pc.q.size() ? pc.q.pop_front() : 8'h0},
                {24'h0, s[i]});
    endtask

    task automatic tend(input string s);
        $display("test %s finished", s);
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // the whole run needs about 11000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        apb(1, 24'h00000c, 32'h2);
        msg("SET5V\r\n");
        apb(0, 24'h000004, 32'h0);
        chk(r, dst_exp(1'b0));
        apb(1, 24'h3ffffc, 32'h0);
        apb(0, 24'h3ffffc, 32'h0);
        chk(r, 32'h9f);
        apb(0, 24'h14 + 24'(rnd() % 60) * 24'h4, 32'h0);
        chk1(e, 1'b1);
        chk(r, 32'h0);
        wt(0, 2500, k);
        wt(0, 2500, k);
        chk(k, 100 * TK);
        chk1(irq_o, 1'b0);
        tend("poll");
        @(posedge clk_i);
        above_upper_i <= 1'b1;
        repeat (9 * TK) @(posedge clk_i);
        above_upper_i <= 1'b0;
        repeat (TK) @(posedge clk_i);
        above_upper_i <= 1'b1;
        wt(2, 20 * TK, k);
        chk1(k >= 9 * TK && k <= 10 * TK + 5, 1'b1);
        msg("START\r\n");
        apb(0, 24'h000000, 32'h0);
        chk(r, ctl_exp(1'b1));
        apb(0, 24'h000008, 32'h0);
        chk(r & 32'h2, 32'h2);
        apb(1, 24'h000008, 32'h2);
        repeat (2) @(negedge clk_i);
        chk1(irq_o, 1'b0);
        tend("stable");
        wt(1, 60 * TK, k);
        c = count_o;
        wt(1, 60 * TK, k);
        chk(k, 50 * TK);
        apb(0, 24'h000010, 32'h0);
        chk(r, {29'h0, c + 3'h1});
        tend("count");
        apb(1, 24'h00000c, 32'h0);
        for (int i = 0; i < 4; i++) begin
            repeat (rnd() % 64) @(posedge clk_i);
            u = i[0];
            above_upper_i <= u;
            msg(u ? "OVER \r\n" : "UNDER\r\n");
            apb(0, 24'h000000, 32'h0);
            chk(r, ctl_exp(u));
            apb(0, 24'h000004, 32'h0);
            chk(r, dst_exp(u));
            chk1(irq_o, i > 0);
            if (i == 0)
                apb(1, 24'h00000c, 32'h1);
        end
        apb(1, 24'h000008, 32'h1);
        repeat (2) @(negedge clk_i);
        chk1(irq_o, 1'b0);
        tend("crossing");
        apb(1, 24'h000000, 32'h000000c3);
        @(posedge clk_i);
        above_upper_i <= 1'b0;
        msg("SET5V\r\n");
        chk({29'h0, count_o}, 32'h0);
        wt(0, 3000, k);
        apb(1, 24'h000008, 32'h7);
        @(posedge clk_i);
        above_lower_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        above_lower_i <= 1'b1;
        @(negedge clk_i);
        chk({28'h0, alarm_o, count_o}, 32'h0);
        apb(0, 24'h000008, 32'h0);
        chk(r & 32'h4, 32'h4);
        apb(0, 24'h000000, 32'h0);
        chk(r & 32'h85, 32'h0);
        msg("SET5V\r\n");
        @(posedge clk_i);
        above_upper_i <= 1'b1;
        msg("START\r\n");
        chk(pc.n_bad, 0);
        tend("restart");
        test_done();
    end
endmodule
